// >>> rtl/pcc_params.svh
// Offsets, field positions, reset values and sizes of the common configuration register block
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// Common configuration byte offsets (structure start is 4-byte aligned)
`define PCC_OFS_OFFER_IDX      12'h000
`define PCC_OFS_OFFER_WIN      12'h004
`define PCC_OFS_ACCEPT_IDX     12'h008
`define PCC_OFS_ACCEPT_WIN     12'h00C
`define PCC_OFS_CFG_VEC        12'h010
`define PCC_OFS_QCOUNT         12'h012
`define PCC_OFS_STATE          12'h014
`define PCC_OFS_GEN            12'h015
`define PCC_OFS_RSEL           12'h016
`define PCC_OFS_RDEPTH         12'h018
`define PCC_OFS_RVEC           12'h01A
`define PCC_OFS_RACTIVE        12'h01C
`define PCC_OFS_RDOORBELL      12'h01E
`define PCC_OFS_DESC_LO        12'h020
`define PCC_OFS_DESC_HI        12'h024
`define PCC_OFS_OFFER_LO       12'h028
`define PCC_OFS_OFFER_HI       12'h02C
`define PCC_OFS_COMP_LO        12'h030
`define PCC_OFS_COMP_HI        12'h034
// Interrupt cause byte, any offset allowed
`define PCC_OFS_CAUSE          12'h040
// Doorbell region base (2-byte aligned) and stride (0 or even power of two)
`define PCC_OFS_DOORBELL_BASE  12'h080
`define PCC_DOORBELL_STRIDE    32'h0000_0004
`define PCC_DOORBELL_LEN       32'h0000_0010

// Cause byte fields
`define PCC_CAUSE_RING_BIT     0
`define PCC_CAUSE_CFG_BIT      1

// Sizes and reset values
`define PCC_NUM_RINGS          4
`define PCC_RING_MAX_DEPTH     16'h0100
`define PCC_OFFERED_FEATURES   64'h0000_0001_0000_0000
`define PCC_VEC_NONE           16'hFFFF

`endif

// >>> rtl/pcc_pkg.sv
// Types shared by the common configuration register block
package pcc_pkg;
	typedef enum logic [1:0] {
		PCC_RUN,
		PCC_RESETTING
	} pcc_state_t;
	typedef logic [15:0] pcc_half_t;
	typedef logic [31:0] pcc_word_t;
endpackage : pcc_pkg

// >>> rtl/pcc_ring_if.sv
// Write strobes and readback of one ring's setup fields
`timescale 1ns/1ps
interface pcc_ring_if;
	logic        soft_rst;
	logic        wr_depth;
	logic        wr_vec;
	logic        wr_active;
	logic [5:0]  wr_base;
	logic [31:0] wdata;
	logic [15:0] depth;
	logic [15:0] vec;
	logic        active;
	logic [63:0] desc_base;
	logic [63:0] offer_base;
	logic [63:0] comp_base;
	modport ctl (output soft_rst, wr_depth, wr_vec, wr_active, wr_base, wdata,
		input depth, vec, active, desc_base, offer_base, comp_base);
	modport ring (input soft_rst, wr_depth, wr_vec, wr_active, wr_base, wdata,
		output depth, vec, active, desc_base, offer_base, comp_base);
endinterface : pcc_ring_if

// >>> rtl/pcc_ring.sv
// Setup fields of one ring: depth, vector, enable and three base addresses
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_ring (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	pcc_ring_if.ring rif
);
	logic [63:0] base_reg [3];

	// Depth and vector return to their reset values on a soft reset
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rif.depth <= `PCC_RING_MAX_DEPTH;
			rif.vec   <= `PCC_VEC_NONE;
		end else if (rif.soft_rst) begin
			rif.depth <= `PCC_RING_MAX_DEPTH;
			rif.vec   <= `PCC_VEC_NONE;
		end else begin
			if (rif.wr_depth)
				rif.depth <= rif.wdata[15:0];
			if (rif.wr_vec)
				rif.vec <= rif.wdata[15:0];
		end
	end

	// Enable is only cleared by reset; a written zero is ignored
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			rif.active <= 1'b0;
		else if (rif.soft_rst)
			rif.active <= 1'b0;
		else if (rif.wr_active && rif.wdata[0])
			rif.active <= 1'b1;
	end

	// Each 64-bit base is written as two independent 32-bit halves
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < 3; i++)
				base_reg[i] <= 64'h0;
		end else if (rif.soft_rst) begin
			for (int i = 0; i < 3; i++)
				base_reg[i] <= 64'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (rif.wr_base[2*i])
					base_reg[i][31:0] <= rif.wdata;
				if (rif.wr_base[2*i+1])
					base_reg[i][63:32] <= rif.wdata;
			end
		end
	end

	assign rif.desc_base  = base_reg[0];
	assign rif.offer_base = base_reg[1];
	assign rif.comp_base  = base_reg[2];
endmodule : pcc_ring

// >>> rtl/pcc_regs.sv
// Common configuration register block of a paravirtualized PCI function
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_regs (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic [11:0] REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	input  wire logic        RING_EVENT,
	input  wire logic        CFG_CHANGED,
	input  wire logic        DEVCFG_RD,
	input  wire logic        MSIX_ENABLED,
	output logic             RING_NOTIFY,
	output logic             CFG_NOTIFY,
	output logic             INTX_PENDING,
	output logic      [31:0] DOORBELL_ADDR,
	output logic [`PCC_NUM_RINGS-1:0] RING_RUN,
	output logic             DEVICE_RESETTING,
	output logic [7:0]       DEVICE_STATE
);
	localparam int NR = `PCC_NUM_RINGS;
	// Doorbell region geometry: the base stays 2-byte aligned and the stride a power of
	// two, so the host can form every ring's address with a shift
	localparam logic [31:0] DB_BASE   = 32'(`PCC_OFS_DOORBELL_BASE);
	localparam logic [31:0] DB_STRIDE = `PCC_DOORBELL_STRIDE;
	localparam logic [31:0] DB_LEN    = `PCC_DOORBELL_LEN;

	// Register state and the combinational helpers around it
	pcc_pkg::pcc_state_t state_reg;
	pcc_pkg::pcc_word_t  offer_idx_reg;
	pcc_pkg::pcc_word_t  accept_idx_reg;
	logic [63:0]         accepted_reg;
	pcc_pkg::pcc_half_t  cfg_vec_reg;
	logic [7:0]          dev_state_reg;
	logic [7:0]          gen_reg;
	logic                changed_reg;
	pcc_pkg::pcc_half_t  rsel_reg;
	logic [7:0]          cause_reg;
	logic [7:0]          cause_next;
	logic                ring_evt_reg;
	logic                cfg_evt_reg;
	logic                soft_rst;
	logic                sel_ok;
	logic [1:0]          sel_idx;
	logic [31:0]         rdata_next;
	logic [31:0]         offer_win;
	logic [31:0]         accept_win;
	logic [63:0]         offered;
	logic                wr_state_zero;
	logic [31:0]         db_offset;
	logic [31:0]         doorbell_next;
	logic [31:0]         doorbell_reg;

	// One interface per ring carries its write strobes and readback
	pcc_ring_if rif [NR] ();

	// Decode shared by the per-ring strobes and the read mux
	assign offered  = `PCC_OFFERED_FEATURES;
	assign sel_ok   = (rsel_reg < 16'(NR));
	assign sel_idx  = rsel_reg[1:0];
	assign soft_rst = (state_reg == pcc_pkg::PCC_RESETTING);
	assign wr_state_zero = REG_WR && (REG_ADDR == `PCC_OFS_STATE) && (REG_WDATA[7:0] == 8'h00);

	// One instance per ring; strobes only reach the selected one
	generate
		for (genvar g = 0; g < NR; g++) begin : g_ring
			assign rif[g].soft_rst  = soft_rst;
			assign rif[g].wdata     = REG_WDATA;
			assign rif[g].wr_depth  = REG_WR && sel_ok && (sel_idx == 2'(g)) && (REG_ADDR == `PCC_OFS_RDEPTH);
			assign rif[g].wr_vec    = REG_WR && sel_ok && (sel_idx == 2'(g)) && (REG_ADDR == `PCC_OFS_RVEC);
			assign rif[g].wr_active = REG_WR && sel_ok && (sel_idx == 2'(g)) && (REG_ADDR == `PCC_OFS_RACTIVE);
			assign rif[g].wr_base   = (REG_WR && sel_ok && (sel_idx == 2'(g))) ? {
				REG_ADDR == `PCC_OFS_COMP_HI, REG_ADDR == `PCC_OFS_COMP_LO,
				REG_ADDR == `PCC_OFS_OFFER_HI, REG_ADDR == `PCC_OFS_OFFER_LO,
				REG_ADDR == `PCC_OFS_DESC_HI, REG_ADDR == `PCC_OFS_DESC_LO} : 6'h00;
			assign RING_RUN[g] = rif[g].active;
			pcc_ring u_ring (
				.SYS_CLK (SYS_CLK),
				.ARST_N  (ARST_N),
				.rif     (rif[g])
			);
		end
	endgenerate

	// Device reset takes one cycle; the state byte reads zero once it is done
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= pcc_pkg::PCC_RUN;
		end else begin
			unique case (state_reg)
				pcc_pkg::PCC_RUN: begin
					if (wr_state_zero)
						state_reg <= pcc_pkg::PCC_RESETTING;
				end
				// A second zero write during the reset cycle stretches it
				pcc_pkg::PCC_RESETTING: begin
					if (!wr_state_zero)
						state_reg <= pcc_pkg::PCC_RUN;
				end
				// Two-bit code leaves room for values no path produces
				default: begin
					state_reg <= pcc_pkg::PCC_RUN;
				end
			endcase
		end
	end

	// State byte; a zero write clears it and launches the soft reset
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			dev_state_reg <= 8'h00;
		else if (REG_WR && (REG_ADDR == `PCC_OFS_STATE))
			dev_state_reg <= REG_WDATA[7:0];
	end

	// Selectors and configuration vector, returned to their reset values by the soft reset too
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			offer_idx_reg  <= 32'h0;
			accept_idx_reg <= 32'h0;
			cfg_vec_reg    <= `PCC_VEC_NONE;
			rsel_reg       <= 16'h0;
		end else if (soft_rst) begin
			offer_idx_reg  <= 32'h0;
			accept_idx_reg <= 32'h0;
			cfg_vec_reg    <= `PCC_VEC_NONE;
			rsel_reg       <= 16'h0;
		end else if (REG_WR) begin
			if (REG_ADDR == `PCC_OFS_OFFER_IDX)
				offer_idx_reg <= REG_WDATA;
			if (REG_ADDR == `PCC_OFS_ACCEPT_IDX)
				accept_idx_reg <= REG_WDATA;
			if (REG_ADDR == `PCC_OFS_CFG_VEC)
				cfg_vec_reg <= REG_WDATA[15:0];
			if (REG_ADDR == `PCC_OFS_RSEL)
				rsel_reg <= REG_WDATA[15:0];
		end
	end

	// Doorbell address is held in a flop and loads in the same edge as the selector
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			doorbell_reg <= DB_BASE;
		else if (soft_rst)
			doorbell_reg <= DB_BASE;
		else if (REG_WR && (REG_ADDR == `PCC_OFS_RSEL))
			doorbell_reg <= doorbell_next;
	end

	// Accepted features keep only offered bits, so unoffered writes read zero
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			accepted_reg <= 64'h0;
		else if (soft_rst)
			accepted_reg <= 64'h0;
		else if (REG_WR && (REG_ADDR == `PCC_OFS_ACCEPT_WIN)) begin
			if (accept_idx_reg == 32'h0)
				accepted_reg[31:0] <= REG_WDATA & offered[31:0];
			else if (accept_idx_reg == 32'h1)
				accepted_reg[63:32] <= REG_WDATA & offered[63:32];
		end
	end

	// Generation bumps only when a changed region is read; the 8-bit count wraps back to zero
	// A change that lands on the read keeps the flag set, so the next read bumps again
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gen_reg     <= 8'h00;
			changed_reg <= 1'b0;
		end else if (DEVCFG_RD && (changed_reg || CFG_CHANGED)) begin
			gen_reg     <= gen_reg + 8'h01;
			changed_reg <= CFG_CHANGED;
		end else if (CFG_CHANGED) begin
			changed_reg <= 1'b1;
		end
	end

	// Cause byte: sets win over the clear done by a read
	always_comb begin
		cause_next = cause_reg;
		if (REG_RD && (REG_ADDR == `PCC_OFS_CAUSE))
			cause_next = 8'h00;
		if (RING_EVENT)
			cause_next[`PCC_CAUSE_RING_BIT] = 1'b1;
		if (CFG_CHANGED)
			cause_next[`PCC_CAUSE_CFG_BIT] = 1'b1;
	end

	// Cause register; reserved bits are never set and read zero
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			cause_reg <= 8'h00;
		else
			cause_reg <= cause_next;
	end

	// Notifications go out on the same edge that sets their cause bit,
	// so the bit is already visible when a notification arrives
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ring_evt_reg <= 1'b0;
			cfg_evt_reg  <= 1'b0;
		end else begin
			ring_evt_reg <= RING_EVENT;
			cfg_evt_reg  <= CFG_CHANGED;
		end
	end

	// Interrupt outputs; the legacy line stays low while message interrupts are on
	assign RING_NOTIFY  = ring_evt_reg;
	assign CFG_NOTIFY   = cfg_evt_reg;
	assign INTX_PENDING = !MSIX_ENABLED && (|cause_reg);
	// Doorbell of the selector being written; index equals ring number
	assign db_offset     = 32'(REG_WDATA[15:0]) * DB_STRIDE;
	// A selector whose doorbell would fall past the region length points at the base
	assign doorbell_next = ((db_offset + 32'h2) <= DB_LEN) ? (DB_BASE + db_offset) : DB_BASE;
	assign DOORBELL_ADDR = doorbell_reg;
	// Status outputs straight from their flops
	assign DEVICE_RESETTING = soft_rst;
	assign DEVICE_STATE     = dev_state_reg;

	// Feature windows: only slices 0 and 1 exist
	always_comb begin
		offer_win = 32'h0;
		if (offer_idx_reg == 32'h0)
			offer_win = offered[31:0];
		else if (offer_idx_reg == 32'h1)
			offer_win = offered[63:32];
		accept_win = 32'h0;
		if (accept_idx_reg == 32'h0)
			accept_win = accepted_reg[31:0];
		else if (accept_idx_reg == 32'h1)
			accept_win = accepted_reg[63:32];
	end

	// Flattened views of the ring interfaces for the read mux loop
	logic [15:0] rif_depth [NR];
	logic [15:0] rif_vec   [NR];
	logic        rif_act   [NR];
	logic [63:0] rif_d     [NR];
	logic [63:0] rif_o     [NR];
	logic [63:0] rif_c     [NR];
	generate
		for (genvar g = 0; g < NR; g++) begin : g_view
			assign rif_depth[g] = rif[g].depth;
			assign rif_vec[g]   = rif[g].vec;
			assign rif_act[g]   = rif[g].active;
			assign rif_d[g]     = rif[g].desc_base;
			assign rif_o[g]     = rif[g].offer_base;
			assign rif_c[g]     = rif[g].comp_base;
		end
	endgenerate

	// Read mux; per-ring fields follow the selector, unavailable rings read zero
	always_comb begin
		logic [15:0] depth_v;
		logic [15:0] vec_v;
		logic        act_v;
		logic [63:0] d_v;
		logic [63:0] o_v;
		logic [63:0] c_v;
		depth_v = 16'h0;
		vec_v   = 16'h0;
		act_v   = 1'b0;
		d_v     = 64'h0;
		o_v     = 64'h0;
		c_v     = 64'h0;
		rdata_next = 32'h0;
		// Fields of the selected ring, zero when no ring is selected
		for (int i = 0; i < NR; i++) begin
			if (sel_ok && (sel_idx == 2'(i))) begin
				depth_v = rif_depth[i];
				vec_v   = rif_vec[i];
				act_v   = rif_act[i];
				d_v     = rif_d[i];
				o_v     = rif_o[i];
				c_v     = rif_c[i];
			end
		end
		// Narrow fields are zero-extended; unmapped offsets read zero
		unique case (REG_ADDR)
			`PCC_OFS_OFFER_IDX:  rdata_next = offer_idx_reg;
			`PCC_OFS_OFFER_WIN:  rdata_next = offer_win;
			`PCC_OFS_ACCEPT_IDX: rdata_next = accept_idx_reg;
			`PCC_OFS_ACCEPT_WIN: rdata_next = accept_win;
			`PCC_OFS_CFG_VEC:    rdata_next = {16'h0, cfg_vec_reg};
			`PCC_OFS_QCOUNT:     rdata_next = 32'(NR);
			`PCC_OFS_STATE:      rdata_next = {24'h0, dev_state_reg};
			`PCC_OFS_GEN:        rdata_next = {24'h0, gen_reg};
			`PCC_OFS_RSEL:       rdata_next = {16'h0, rsel_reg};
			`PCC_OFS_RDEPTH:     rdata_next = {16'h0, depth_v};
			`PCC_OFS_RVEC:       rdata_next = {16'h0, vec_v};
			`PCC_OFS_RACTIVE:    rdata_next = {31'h0, act_v};
			`PCC_OFS_RDOORBELL:  rdata_next = sel_ok ? {16'h0, rsel_reg} : 32'h0;
			`PCC_OFS_DESC_LO:    rdata_next = d_v[31:0];
			`PCC_OFS_DESC_HI:    rdata_next = d_v[63:32];
			`PCC_OFS_OFFER_LO:   rdata_next = o_v[31:0];
			`PCC_OFS_OFFER_HI:   rdata_next = o_v[63:32];
			`PCC_OFS_COMP_LO:    rdata_next = c_v[31:0];
			`PCC_OFS_COMP_HI:    rdata_next = c_v[63:32];
			`PCC_OFS_CAUSE:      rdata_next = {24'h0, cause_reg};
			default:             rdata_next = 32'h0;
		endcase
	end

	// Registered read data, one cycle after the read strobe
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			REG_RDATA <= 32'h0;
		else if (REG_RD)
			REG_RDATA <= rdata_next;
	end
endmodule : pcc_regs

// >>> testbench/pcc_regs_chk.sv
// Port assertions for the common configuration register block
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_regs_chk (
	input wire logic                     SYS_CLK,
	input wire logic                     ARST_N,
	input wire logic [11:0]              REG_ADDR,
	input wire logic                     REG_WR,
	input wire logic                     REG_RD,
	input wire logic [31:0]              REG_WDATA,
	input wire logic [31:0]              REG_RDATA,
	input wire logic                     RING_EVENT,
	input wire logic                     CFG_CHANGED,
	input wire logic                     MSIX_ENABLED,
	input wire logic                     RING_NOTIFY,
	input wire logic                     CFG_NOTIFY,
	input wire logic                     INTX_PENDING,
	input wire logic [31:0]              DOORBELL_ADDR,
	input wire logic [`PCC_NUM_RINGS-1:0] RING_RUN,
	input wire logic                     DEVICE_RESETTING,
	input wire logic [7:0]               DEVICE_STATE
);
	// All checks share the one clock domain
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	chk_ring_notify: assert property ((RING_EVENT && !MSIX_ENABLED) ##1 !MSIX_ENABLED |-> RING_NOTIFY && INTX_PENDING)
		else $error("ring notify without cause bit");
	chk_cfg_notify: assert property (CFG_CHANGED |=> CFG_NOTIFY && (MSIX_ENABLED || INTX_PENDING))
		else $error("config notify without cause bit");
	chk_intx_masked: assert property (MSIX_ENABLED |-> !INTX_PENDING)
		else $error("legacy interrupt while message interrupts on");
	chk_cause_clear: assert property (REG_RD && REG_ADDR == `PCC_OFS_CAUSE && !RING_EVENT && !CFG_CHANGED |=> !INTX_PENDING)
		else $error("interrupt still pending after cause read");
	chk_doorbell_addr: assert property (REG_WR && REG_ADDR == `PCC_OFS_RSEL && REG_WDATA[15:0] < 16'h0004 |=>
		DOORBELL_ADDR == 32'(`PCC_OFS_DOORBELL_BASE) + 32'($past(REG_WDATA[15:0])) * `PCC_DOORBELL_STRIDE)
		else $error("doorbell address wrong for selected ring");
	chk_state_reset: assert property (REG_WR && REG_ADDR == `PCC_OFS_STATE && REG_WDATA[7:0] == 8'h00 |=>
		DEVICE_RESETTING && DEVICE_STATE == 8'h00)
		else $error("zero state write did not reset");
	chk_ring_stop: assert property (DEVICE_RESETTING |=> RING_RUN == '0)
		else $error("ring still running after soft reset");
	chk_run_cause: assert property (|(RING_RUN & ~$past(RING_RUN)) |->
		$past(REG_WR && REG_ADDR == `PCC_OFS_RACTIVE && REG_WDATA[0]))
		else $error("ring started without enable write");
	chk_offer_high: assert property (REG_WR && REG_ADDR == `PCC_OFS_OFFER_IDX && REG_WDATA > 32'h1 ##2
		REG_RD && REG_ADDR == `PCC_OFS_OFFER_WIN |=> REG_RDATA == 32'h0)
		else $error("offered window nonzero above slice one");
endmodule : pcc_regs_chk
bind pcc_regs pcc_regs_chk pcc_regs_chk_inst (.SYS_CLK, .ARST_N, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
	.RING_EVENT, .CFG_CHANGED, .MSIX_ENABLED, .RING_NOTIFY, .CFG_NOTIFY, .INTX_PENDING, .DOORBELL_ADDR, .RING_RUN,
	.DEVICE_RESETTING, .DEVICE_STATE);

// >>> testbench/pcc_host_model.sv
// Host driver model issuing register reads and writes
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_host_model (
	input  wire logic        clk,
	input  wire logic [31:0] rdata,
	output logic      [11:0] addr,
	output logic             wr,
	output logic             rd,
	output logic      [31:0] wdata
);
	// Bus idles on an unmapped address with flipped data so stale values never look valid
	initial begin
		addr = 12'hFFF;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 32'h0;
	end
	// One access: set after a falling edge, taken at the rising edge, released at the next falling edge
	task automatic cyc(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(negedge clk);
		addr = a;
		wr = w;
		rd = !w;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'hFFF;
		wdata = ~d;
		q = rdata;
	endtask : cyc
	// Writes a real driver would never make are dropped here
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		if (a == `PCC_OFS_OFFER_WIN || a == `PCC_OFS_QCOUNT || a == `PCC_OFS_GEN || a == `PCC_OFS_RDOORBELL) return;
		if (a == `PCC_OFS_RACTIVE && d[15:0] == 16'h0000) return;
		if (a == `PCC_OFS_RDEPTH && (d[15:0] & (d[15:0] - 16'h0001)) != 16'h0000) return;
		cyc(a, 1'b1, d, q);
	endtask : wr_reg
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] q);
		cyc(a, 1'b0, 32'h0, q);
	endtask : rd_reg
	// Bounded poll of the state byte after a soft reset
	task automatic poll_idle(output int n);
		logic [31:0] v;
		n = 0;
		do begin
			cyc(`PCC_OFS_STATE, 1'b0, 32'h0, v);
			n++;
		end while (v[7:0] !== 8'h00 && n < 16);
	endtask : poll_idle
endmodule : pcc_host_model

// >>> testbench/tb.sv
// Self-checking testbench of the common configuration register block
`timescale 1ns/1ps
`include "pcc_params.svh"
module tb;
	logic                      SYS_CLK = 1'b0;
	logic                      ARST_N, REG_WR, REG_RD, RING_EVENT, CFG_CHANGED, DEVCFG_RD, MSIX_ENABLED;
	logic [11:0]               REG_ADDR;
	logic [31:0]               REG_WDATA, REG_RDATA, DOORBELL_ADDR, q, d;
	logic                      RING_NOTIFY, CFG_NOTIFY, INTX_PENDING, DEVICE_RESETTING;
	logic [`PCC_NUM_RINGS-1:0] RING_RUN;
	logic [7:0]                DEVICE_STATE, g;
	logic [15:0]               dep [4];
	int                        miscompares = 0;
	int                        comparisons = 0;
	int                        n;
	always #10 SYS_CLK = ~SYS_CLK;
	pcc_regs pcc_regs_inst (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .RING_EVENT(RING_EVENT), .CFG_CHANGED(CFG_CHANGED),
		.DEVCFG_RD(DEVCFG_RD), .MSIX_ENABLED(MSIX_ENABLED), .RING_NOTIFY(RING_NOTIFY), .CFG_NOTIFY(CFG_NOTIFY),
		.INTX_PENDING(INTX_PENDING), .DOORBELL_ADDR(DOORBELL_ADDR), .RING_RUN(RING_RUN),
		.DEVICE_RESETTING(DEVICE_RESETTING), .DEVICE_STATE(DEVICE_STATE));
	pcc_host_model pcc_host_model_inst (.clk(SYS_CLK), .rdata(REG_RDATA), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD),
		.wdata(REG_WDATA));
	// Offered slice for a selector; nothing is offered above bit 63
	function automatic logic [31:0] offer_slice(input logic [31:0] s);
		logic [63:0] f;
		f = `PCC_OFFERED_FEATURES;
		return (s == 32'h0) ? f[31:0] : (s == 32'h1) ? f[63:32] : 32'h0;
	endfunction : offer_slice
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		pcc_host_model_inst.wr_reg(a, v);
	endtask : wr
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		pcc_host_model_inst.rd_reg(a, v);
		chk(nm, e, v);
	endtask : rdc
	task automatic pulse(ref logic s);
		@(negedge SYS_CLK);
		s = 1'b1;
		@(negedge SYS_CLK);
		s = 1'b0;
	endtask : pulse
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		{ARST_N, RING_EVENT, CFG_CHANGED, DEVCFG_RD, MSIX_ENABLED} = 5'h00;
		q = $urandom(32'h7AB274F4);
		repeat (2) @(negedge SYS_CLK);
		ARST_N = 1'b1;
		rdc("state", `PCC_OFS_STATE, 32'h0);
		rdc("active", `PCC_OFS_RACTIVE, 32'h0);
		rdc("depth", `PCC_OFS_RDEPTH, 32'(`PCC_RING_MAX_DEPTH));
		for (int i = 0; i < 4; i++) begin
			d = (i < 3) ? i : ($urandom % 32'hFFFF) + 32'h2;
			wr(`PCC_OFS_OFFER_IDX, d);
			rdc("offer", `PCC_OFS_OFFER_WIN, offer_slice(d));
		end
		for (int i = 0; i < 2; i++) begin
			d = $urandom;
			wr(`PCC_OFS_ACCEPT_IDX, i);
			wr(`PCC_OFS_ACCEPT_WIN, d);
			rdc("accept", `PCC_OFS_ACCEPT_WIN, d & offer_slice(i));
		end
		$display("test features done");
		// Every ring gets depth, vector and descriptor base before its enable; ring four does not exist
		for (int r = 0; r < 5; r++) begin
			d = 32'h1 << ($urandom % 9);
			wr(`PCC_OFS_RSEL, r);
			wr(`PCC_OFS_RDEPTH, d);
			wr(`PCC_OFS_RVEC, r);
			wr(`PCC_OFS_DESC_LO, d ^ r);
			wr(`PCC_OFS_DESC_HI, ~d);
			wr(`PCC_OFS_RACTIVE, 32'h1);
			if (r == 4) chk("doorbell", 32'(`PCC_OFS_DOORBELL_BASE), DOORBELL_ADDR);
			if (r == 4) rdc("depth", `PCC_OFS_RDEPTH, 32'h0);
			if (r == 4) break;
			dep[r] = d[15:0];
			chk("doorbell", 32'(`PCC_OFS_DOORBELL_BASE) + r * `PCC_DOORBELL_STRIDE, DOORBELL_ADDR);
			rdc("ring index", `PCC_OFS_RDOORBELL, r);
			rdc("vector", `PCC_OFS_RVEC, r);
			rdc("desc lo", `PCC_OFS_DESC_LO, d ^ r);
			rdc("desc hi", `PCC_OFS_DESC_HI, ~d);
			rdc("active", `PCC_OFS_RACTIVE, 32'h1);
		end
		wr(`PCC_OFS_RSEL, 32'h1);
		d = DOORBELL_ADDR - 32'(`PCC_OFS_DOORBELL_BASE);
		chk("stride", 32'h0, d & (d - 32'h1));
		chk("doorbell align", 32'h0, DOORBELL_ADDR & 32'h1);
		rdc("depth", `PCC_OFS_RDEPTH, dep[1]);
		chk("run", 32'hF, RING_RUN);
		$display("test rings done");
		pulse(RING_EVENT);
		chk("intx", 32'h1, INTX_PENDING);
		rdc("cause", `PCC_OFS_CAUSE, 32'h1);
		rdc("cause", `PCC_OFS_CAUSE, 32'h0);
		pulse(CFG_CHANGED);
		rdc("cause", `PCC_OFS_CAUSE, 32'h2);
		// Event landing on the same edge as the clearing read must not be lost
		fork
			pcc_host_model_inst.rd_reg(`PCC_OFS_CAUSE, q);
			pulse(RING_EVENT);
		join
		chk("cause", 32'h0, q);
		rdc("cause", `PCC_OFS_CAUSE, 32'h1);
		@(negedge SYS_CLK) MSIX_ENABLED = 1'b1;
		pulse(RING_EVENT);
		chk("intx", 32'h0, INTX_PENDING);
		@(negedge SYS_CLK) MSIX_ENABLED = 1'b0;
		rdc("cause", `PCC_OFS_CAUSE, 32'h1);
		pcc_host_model_inst.rd_reg(`PCC_OFS_GEN, q);
		g = q[7:0];
		pulse(CFG_CHANGED);
		pulse(DEVCFG_RD);
		pcc_host_model_inst.rd_reg(`PCC_OFS_GEN, q);
		chk("generation", g + 8'h01, q[7:0]);
		pulse(DEVCFG_RD);
		pcc_host_model_inst.rd_reg(`PCC_OFS_GEN, q);
		chk("generation", g + 8'h01, q[7:0]);
		$display("test interrupts done");
		wr(`PCC_OFS_STATE, 32'h0F);
		rdc("state", `PCC_OFS_STATE, 32'h0F);
		wr(`PCC_OFS_STATE, 32'h0);
		chk("state", 32'h0, DEVICE_STATE);
		pcc_host_model_inst.poll_idle(n);
		chk("poll", 32'h1, n);
		chk("run", 32'h0, RING_RUN);
		rdc("depth", `PCC_OFS_RDEPTH, 32'(`PCC_RING_MAX_DEPTH));
		$display("test soft reset done");
		report_and_stop();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#(20 * 5000);
		miscompares++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule : tb
